/* File: verilog/idx_param_access.sv */
// Object dictionary slice: selector objects, one indexed data object, and
// the digital input and output status objects.
// Assumes one access per cycle, answered in the following cycle.
`timescale 1ns/1ps
module idx_param_access
    import idx_param_pkg::*;
#(
    parameter int ENTRIES = 32,
    parameter int DW = 32
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Service channel request
    input wire logic REQ,
    input wire logic REQ_WRITE,
    input wire logic [15:0] REQ_INDEX,
    input wire logic [7:0] REQ_SUBINDEX,
    input wire logic [DW-1:0] REQ_DATA,
    // Service channel answer
    output logic ACK,
    output logic [1:0] ACK_RESP,
    output logic [DW-1:0] ACK_DATA,
    // Live drive signals
    input wire logic [15:0] DIN_LIVE,
    input wire logic MFI_LIVE,
    input wire logic [7:0] MFI_MODE,
    input wire logic [15:0] DOUT_LIVE,
    input wire logic MFO_LIVE,
    input wire logic [7:0] MFO_MODE,
    // Selection state
    output logic [15:0] WR_SEL,
    output logic [15:0] RD_SEL
);
    localparam int EB = 5;

    idx_param_if #(.ENTRY_BITS(EB), .DW(DW)) acc ();

    logic [15:0] wr_sel_q, wr_sel_d;
    logic [15:0] rd_sel_q, rd_sel_d;
    logic ack_q;
    logic [1:0] resp_q, resp_d;
    logic [DW-1:0] data_q, data_d;

    wire [15:0] idx_wr_sel = PARAM_BASE + WR_SEL_PARAM;
    wire [15:0] idx_rd_sel = PARAM_BASE + RD_SEL_PARAM;
    wire [15:0] idx_data = PARAM_BASE + FIRST_DATA_PARAM;
    wire hit_wsel = REQ_INDEX == idx_wr_sel;
    wire hit_rsel = REQ_INDEX == idx_rd_sel;
    wire hit_data = REQ_INDEX == idx_data;
    wire hit_din = REQ_INDEX == DIN_STATE_IDX;
    wire hit_dout = REQ_INDEX == DOUT_STATE_IDX;

    wire [7:0] new_dec = decode_wr_sel(REQ_DATA[15:0], ENTRIES);
    wire [7:0] cur_dec = decode_wr_sel(wr_sel_q, ENTRIES);
    wire rd_sel_ok = REQ_DATA[15:0] >= 16'h0001 &&
                     REQ_DATA[15:0] <= 16'(ENTRIES);

    // Plain data-set subindex; plus five selects the volatile copy.
    wire ds_vol = REQ_SUBINDEX[3:0] > MAX_NV_DS;
    wire ds_ok = REQ_SUBINDEX <= 8'(MAX_NV_DS + VOLATILE_DS_OFFSET);

    wire mfi_on = MFI_MODE == MFI_DIGITAL_MODE;
    wire mfo_on = MFO_MODE == MFO_DIGITAL_MODE;
    wire [15:0] din_word = {DIN_LIVE[15:1], DIN_LIVE[0] | (mfi_on & MFI_LIVE)};
    wire [15:0] dout_word = {DOUT_LIVE[15:1],
                             DOUT_LIVE[0] | (mfo_on & MFO_LIVE)};

    wire wsel_good = REQ && REQ_WRITE && hit_wsel && new_dec[7];
    wire rsel_good = REQ && REQ_WRITE && hit_rsel && rd_sel_ok;
    wire data_wr = REQ && REQ_WRITE && hit_data && cur_dec[7] && ds_ok;

    assign acc.wr_en = data_wr;
    assign acc.wr_all = cur_dec[5];
    assign acc.wr_volatile = cur_dec[6] | ds_vol;
    assign acc.wr_entry = cur_dec[4:0];
    assign acc.rd_entry = EB'(rd_sel_q - 16'h0001);
    assign acc.wr_data = REQ_DATA;

    always_comb begin
        wr_sel_d = wsel_good ? REQ_DATA[15:0] : wr_sel_q;
        rd_sel_d = rsel_good ? REQ_DATA[15:0] : rd_sel_q;
        resp_d = RESP_OK;
        data_d = '0;
        if (hit_wsel) begin
            if (REQ_WRITE && !new_dec[7]) begin
                resp_d = RESP_BAD_VALUE;
            end
            data_d = DW'(wr_sel_q);
        end else if (hit_rsel) begin
            if (REQ_WRITE && !rd_sel_ok) begin
                resp_d = RESP_BAD_VALUE;
            end
            data_d = DW'(rd_sel_q);
        end else if (hit_data) begin
            if (!ds_ok || (REQ_WRITE && !cur_dec[7])) begin
                resp_d = RESP_BAD_VALUE;
            end
            data_d = ds_vol ? acc.vol_data : acc.nv_data;
        end else if (hit_din) begin
            if (REQ_WRITE) begin
                resp_d = RESP_READ_ONLY;
            end
            data_d = DW'(din_word);
        end else if (hit_dout) begin
            if (REQ_WRITE) begin
                resp_d = RESP_READ_ONLY;
            end
            data_d = DW'(dout_word);
        end else begin
            resp_d = RESP_NO_OBJECT;
        end
        if (REQ_WRITE) begin
            data_d = '0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_sel_q <= WR_SEL_RESET;
            rd_sel_q <= RD_SEL_RESET;
            ack_q <= 1'b0;
            resp_q <= 2'h0;
            data_q <= '0;
        end else begin
            wr_sel_q <= wr_sel_d;
            rd_sel_q <= rd_sel_d;
            ack_q <= REQ;
            resp_q <= REQ ? resp_d : 2'h0;
            data_q <= REQ ? data_d : '0;
        end
    end

    idx_entry_store #(.ENTRIES(ENTRIES), .DW(DW)) u_store (
        .CLK(CLK),
        .RST(RST),
        .acc(acc)
    );

    assign ACK = ack_q;
    assign ACK_RESP = resp_q;
    assign ACK_DATA = data_q;
    assign WR_SEL = wr_sel_q;
    assign RD_SEL = rd_sel_q;
endmodule // idx_param_access

/* File: verilog/idx_param_pkg.sv */
// Constants, types and helpers shared by the indexed parameter access block.
// Assumes a service channel that presents one object access per cycle.
// Summary of operation
// - Indexed functions hold 16 or 32 entries.
// - Selector picks entry and storage kind.
// - Zero writes all nonvolatile; 17/33 all volatile.
// - Entry plus 17/33 writes that volatile entry.
// - Data set plus five means volatile.
// - Object index equals parameter number plus 0x2000.
// - Write selection held across several writes.
// - Volatile values lost at power loss.
// - Input status read-only, MF input if mode 3.
// - Output status read-only, MF output if mode 1.
package idx_param_pkg;
    localparam logic [15:0] PARAM_BASE = 16'h2000;
    localparam logic [15:0] WR_SEL_PARAM = 16'h04b0;
    localparam logic [15:0] RD_SEL_PARAM = 16'h04b1;
    localparam logic [15:0] FIRST_DATA_PARAM = 16'h04b2;
    localparam logic [15:0] DIN_STATE_IDX = 16'h3001;
    localparam logic [15:0] DOUT_STATE_IDX = 16'h3002;
    localparam logic [7:0] MFI_DIGITAL_MODE = 8'h03;
    localparam logic [7:0] MFO_DIGITAL_MODE = 8'h01;
    localparam logic [3:0] VOLATILE_DS_OFFSET = 4'h5;
    localparam logic [3:0] MAX_NV_DS = 4'h4;
    localparam logic [15:0] WR_SEL_RESET = 16'h0001;
    localparam logic [15:0] RD_SEL_RESET = 16'h0001;

    typedef enum logic [1:0] {
        RESP_OK,
        RESP_NO_OBJECT,
        RESP_READ_ONLY,
        RESP_BAD_VALUE
    } resp_t;

    // Maps a write selector to entry and storage kind; valid low if illegal.
    function automatic logic [7:0] decode_wr_sel(input logic [15:0] v,
                                                 input int unsigned n);
        logic [7:0] r;
        r = 8'h00;
        if (v == 16'h0000) begin
            r = {1'b1, 1'b0, 1'b1, 5'h00};
        end else if (v <= 16'(n)) begin
            r = {1'b1, 1'b0, 1'b0, 5'(v - 16'h0001)};
        end else if (v == 16'(n + 1)) begin
            r = {1'b1, 1'b1, 1'b1, 5'h00};
        end else if (v <= 16'(2 * n + 1)) begin
            r = {1'b1, 1'b1, 1'b0, 5'(v - 16'(n + 2))};
        end
        return r;
    endfunction
endpackage

/* File: verilog/idx_param_if.sv */
// Carries one indexed object access from the decoder to the entry store.
// Assumes both ends share the block clock.
`timescale 1ns/1ps
interface idx_param_if #(parameter int ENTRY_BITS = 5, parameter int DW = 32);
    logic wr_en;
    logic wr_all;
    logic wr_volatile;
    logic [ENTRY_BITS-1:0] wr_entry;
    logic [ENTRY_BITS-1:0] rd_entry;
    logic [DW-1:0] wr_data;
    logic [DW-1:0] nv_data;
    logic [DW-1:0] vol_data;
    modport ctrl (output wr_en, wr_all, wr_volatile, wr_entry, rd_entry,
                  wr_data, input nv_data, vol_data);
    modport store (input wr_en, wr_all, wr_volatile, wr_entry, rd_entry,
                   wr_data, output nv_data, vol_data);
endinterface

/* File: verilog/idx_entry_store.sv */
// Entry storage for one indexed parameter, nonvolatile and volatile copies.
// Assumes the nonvolatile copy is backed externally; volatile is lost.
`timescale 1ns/1ps
module idx_entry_store #(
    parameter int ENTRIES = 32,
    parameter int DW = 32
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Access port
    idx_param_if.store acc
);
    logic [DW-1:0] nv_q [ENTRIES];
    logic [DW-1:0] vol_q [ENTRIES];

    for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
        wire hit = acc.wr_en && (acc.wr_all || acc.wr_entry == i);
        always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
                nv_q[i] <= '0;
                vol_q[i] <= '0;
            end else if (hit && acc.wr_volatile) begin
                vol_q[i] <= acc.wr_data;
            end else if (hit) begin
                // A nonvolatile write also refreshes the working copy.
                nv_q[i] <= acc.wr_data;
                vol_q[i] <= acc.wr_data;
            end
        end
    end

    assign acc.nv_data = nv_q[acc.rd_entry];
    assign acc.vol_data = vol_q[acc.rd_entry];
endmodule // idx_entry_store

/* File: tb/fb_master.sv */
// Fieldbus master model that drives the block's service channel.
// Assumes each access is answered exactly one cycle after it is taken.
`timescale 1ns/1ps
module fb_master (
    // Clock
    input wire logic CLK,
    // Request
    output logic REQ,
    output logic REQ_WRITE,
    output logic [15:0] REQ_INDEX,
    output logic [7:0] REQ_SUBINDEX,
    output logic [31:0] REQ_DATA,
    // Answer
    input wire logic ACK,
    input wire logic [1:0] ACK_RESP,
    input wire logic [31:0] ACK_DATA
);
    initial begin
        REQ = 1'b0;
        REQ_WRITE = 1'b0;
        REQ_INDEX = 16'h0000;
        REQ_SUBINDEX = 8'h00;
        REQ_DATA = 32'h0000_0000;
    end

    task automatic xfer(input logic w, input logic [15:0] i,
        input logic [7:0] s, input logic [31:0] d,
        output logic a, output logic [1:0] r, output logic [31:0] q);
        @(negedge CLK);
        REQ = 1'b1;
        REQ_WRITE = w;
        REQ_INDEX = i;
        REQ_SUBINDEX = s;
        REQ_DATA = d;
        @(negedge CLK);
        a = ACK;
        r = ACK_RESP;
        q = ACK_DATA;
        REQ = 1'b0;
        // Released fields must not keep looking like a valid request.
        REQ_INDEX = ~i;
        REQ_DATA = ~d;
    endtask
endmodule // fb_master

/* File: tb/idx_param_access_props.sv */
// Service channel checks for the indexed parameter block.
// Bound to the block and sees only its ports.
`timescale 1ns/1ps
module idx_param_access_props
    import idx_param_pkg::*;
#(
    parameter int ENTRIES = 32,
    parameter int DW = 32
) (
    // Channel and status inputs
    input wire logic CLK, RST, REQ, REQ_WRITE, ACK, MFI_LIVE,
    input wire logic [15:0] REQ_INDEX, WR_SEL, RD_SEL, DIN_LIVE,
    input wire logic [DW-1:0] REQ_DATA, ACK_DATA,
    input wire logic [1:0] ACK_RESP,
    input wire logic [7:0] MFI_MODE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire wr = REQ && REQ_WRITE;
    wire [15:0] v = REQ_DATA[15:0];
    wire wsel = wr && REQ_INDEX == PARAM_BASE + WR_SEL_PARAM;
    wire rsel = wr && REQ_INDEX == PARAM_BASE + RD_SEL_PARAM;
    wire wok = v <= 16'(2 * ENTRIES + 1);
    wire mfi = MFI_LIVE && MFI_MODE == MFI_DIGITAL_MODE;
    wire [15:0] din = DIN_LIVE | {15'h0000, mfi};
    a_ack_next:
        assert property (REQ |=> ACK) else $error("no ack");
    a_ack_idle:
        assert property (!REQ |=> !ACK) else $error("stray ack");
    a_wsel_take:
        assert property (wsel && wok |=> WR_SEL == $past(v))
        else $error("wr sel");
    a_wsel_keep:
        assert property (wsel && !wok |=> ACK_RESP == 2'h3 && $stable(WR_SEL))
        else $error("bad wr sel");
    a_rsel_take:
        assert property (rsel && v != 16'h0000 && v <= 16'(ENTRIES)
            |=> RD_SEL == $past(v)) else $error("rd sel");
    a_sel_hold:
        assert property (!wr |=> $stable(WR_SEL) && $stable(RD_SEL))
        else $error("sel moved");
    a_status_ro:
        assert property (wr && (REQ_INDEX == DIN_STATE_IDX
            || REQ_INDEX == DOUT_STATE_IDX) |=> ACK_RESP == 2'h2)
        else $error("status written");
    a_din_live:
        assert property (REQ && !REQ_WRITE && REQ_INDEX == DIN_STATE_IDX
            |=> ACK_DATA == DW'($past(din))) else $error("din");
endmodule // idx_param_access_props

bind idx_param_access idx_param_access_props #(.ENTRIES(ENTRIES), .DW(DW))
    props_i (.CLK(CLK), .RST(RST), .REQ(REQ), .REQ_WRITE(REQ_WRITE),
    .ACK(ACK), .MFI_LIVE(MFI_LIVE), .REQ_INDEX(REQ_INDEX), .WR_SEL(WR_SEL),
    .RD_SEL(RD_SEL), .DIN_LIVE(DIN_LIVE), .REQ_DATA(REQ_DATA),
    .ACK_DATA(ACK_DATA), .ACK_RESP(ACK_RESP), .MFI_MODE(MFI_MODE));

/* File: tb/tb_top.sv */
// Self-checking bench for the indexed parameter block.
// Assumes the master model launches one access per call.
`timescale 1ns/1ps
module tb_top;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic MFI_LIVE = 1'b1;
    logic MFO_LIVE = 1'b1;
    logic [7:0] MFI_MODE = 8'h03;
    logic [7:0] MFO_MODE = 8'h00;
    logic [15:0] DIN_LIVE = 16'h00a4;
    logic [15:0] DOUT_LIVE = 16'h0030;
    logic [15:0] WR_SEL, RD_SEL, REQ_INDEX;
    logic REQ, REQ_WRITE, ACK;
    logic [7:0] REQ_SUBINDEX;
    logic [1:0] ACK_RESP;
    logic [31:0] REQ_DATA, ACK_DATA;
    int mismatches = 0;
    int comparisons = 0;
    always #4 CLK = ~CLK;
    idx_param_access idx_param_access_i (.CLK(CLK), .RST(RST), .REQ(REQ),
        .REQ_WRITE(REQ_WRITE), .REQ_INDEX(REQ_INDEX),
        .REQ_SUBINDEX(REQ_SUBINDEX), .REQ_DATA(REQ_DATA), .ACK(ACK),
        .ACK_RESP(ACK_RESP), .ACK_DATA(ACK_DATA), .DIN_LIVE(DIN_LIVE),
        .MFI_LIVE(MFI_LIVE), .MFI_MODE(MFI_MODE), .DOUT_LIVE(DOUT_LIVE),
        .MFO_LIVE(MFO_LIVE), .MFO_MODE(MFO_MODE), .WR_SEL(WR_SEL),
        .RD_SEL(RD_SEL));
    fb_master fb_master_i (.CLK(CLK), .REQ(REQ), .REQ_WRITE(REQ_WRITE),
        .REQ_INDEX(REQ_INDEX), .REQ_SUBINDEX(REQ_SUBINDEX),
        .REQ_DATA(REQ_DATA), .ACK(ACK), .ACK_RESP(ACK_RESP),
        .ACK_DATA(ACK_DATA));

    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] i,
        input logic [7:0] s, input logic [31:0] d, input logic [1:0] er,
        input logic [31:0] ed);
        logic a;
        logic [1:0] r;
        logic [31:0] q;
        fb_master_i.xfer(w, i, s, d, a, r, q);
        chk("ack", 32'h1, {31'h0, a});
        chk("resp", {30'h0, er}, {30'h0, r});
        chk("data", ed, q);
    endtask

    task automatic finish_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The sequence needs well under a thousand cycles.
    initial begin
        #20000;
        mismatches++;
        finish_test;
    end

    initial begin
        repeat (20) @(negedge CLK);
        RST = 1'b0;
        chk("wr_sel", 32'h1, {16'h0, WR_SEL});
        acc(1, 16'h24b0, 0, 34, 0, 0);
        acc(1, 16'h24b2, 0, 30000, 0, 0);
        acc(0, 16'h24b2, 5, 0, 0, 30000);
        acc(0, 16'h24b2, 0, 0, 0, 0);
        acc(1, 16'h24b0, 0, 0, 0, 0);
        acc(1, 16'h24b2, 0, 7, 0, 0);
        acc(1, 16'h24b0, 0, 33, 0, 0);
        acc(1, 16'h24b2, 0, 9, 0, 0);
        acc(1, 16'h24b1, 0, 32, 0, 0);
        acc(0, 16'h24b2, 0, 0, 0, 7);
        acc(0, 16'h24b2, 5, 0, 0, 9);
        acc(1, 16'h24b0, 0, 66, 3, 0);
        chk("wr_sel", 32'd33, {16'h0, WR_SEL});
        acc(1, 16'h24b0, 0, 2, 0, 0);
        acc(1, 16'h24b2, 5, 5, 0, 0);
        acc(1, 16'h24b1, 0, 2, 0, 0);
        acc(0, 16'h24b2, 0, 0, 0, 7);
        acc(0, 16'h24b2, 5, 0, 0, 5);
        acc(0, 16'h3001, 0, 0, 0, 32'h00a5);
        MFI_MODE = 8'h00;
        acc(0, 16'h3001, 0, 0, 0, 32'h00a4);
        acc(0, 16'h3002, 0, 0, 0, 32'h0030);
        MFO_MODE = 8'h01;
        acc(0, 16'h3002, 0, 0, 0, 32'h0031);
        acc(1, 16'h3001, 0, 1, 2, 0);
        acc(0, 16'h2000, 0, 0, 1, 0);
        finish_test;
    end
endmodule // tb_top
